// File: common/aff_regs.vh
// constants for the auxiliary data field parser: register map, field layout, codes
// assumes inclusion by bare name from the parser module; definitions only
//
// Functional notes
// - short field is exactly four bytes
// - short: tag plus three data, or four data
// - short: tag needed at group start or resume
// - short: tag omitted only for same-application continuation
// - unfilled sub-field tail is zero padding
// - tag present flag tells whether tags exist
// - variable: length varies, tag list comes first
// - variable tag gives type and sub-field length
// - at most four sub-fields, each tagged
// - tag order matches sub-field order
// - tags one byte, list at most four
// - short list closed by type zero marker
// - sender includes list in listed cases
// - list omitted only for same length continuation
// - type zero also means no data
// - type 1 length, 2 and 3 label
// - types 12 to 15 object transfer only
// - type 31 never sent, invalid on receipt
// - user types 4-11 and 16-30
// - short tag: three zero bits, five type bits
// - variable length code maps to byte counts
// - field bytes reversed, tags sent last
// - mode: none, short, variable, reserved
// - flag zero no tags, one some tags
`ifndef AFF_REGS_VH
`define AFF_REGS_VH

// register byte offsets
`define AFF_REG_CTRL 8'h00
`define AFF_REG_STATUS 8'h04
`define AFF_REG_ERR 8'h08
`define AFF_REG_COUNT 8'h0C

// control fields
`define AFF_CTRL_EN 0
`define AFF_CTRL_DROP_BAD 1
`define AFF_CTRL_RESET 2'h0

// error bit positions
`define AFF_ERR_SHORT_LEN 0
`define AFF_ERR_RSVD 1
`define AFF_ERR_NO_CTX 2
`define AFF_ERR_TOTAL 3
`define AFF_ERR_TYPE31 4
`define AFF_ERR_MODE 5
`define AFF_ERR_OVF 6
`define AFF_ERR_W 7

// mode indicator codes
`define AFF_MODE_NONE 2'h0
`define AFF_MODE_SHORT 2'h1
`define AFF_MODE_VAR 2'h2

// field layout
`define AFF_TYPE_MSB 4
`define AFF_LEN_LSB 5
`define AFF_SHORT_BYTES 8'h04
`define AFF_SHORT_DATA 6'h03
`define AFF_MAX_TAGS 3'h4
`define AFF_MAX_FIELD 8'hC4

// application type codes
`define AFF_TYPE_END 5'h00
`define AFF_TYPE_LEN_IND 5'h01
`define AFF_TYPE_LABEL_S 5'h02
`define AFF_TYPE_LABEL_C 5'h03
`define AFF_TYPE_OBJ_LO 5'h0C
`define AFF_TYPE_OBJ_HI 5'h0F
`define AFF_TYPE_BAD 5'h1F

// application classes on the output
`define AFF_CLS_LEN 3'h1
`define AFF_CLS_LABEL 3'h2
`define AFF_CLS_OBJ 3'h3
`define AFF_CLS_USER 3'h4
`define AFF_CLS_BAD 3'h5

`endif

// File: verilog/aff_parser.v
// receive-side parser for the auxiliary data field of one audio frame
// assumes field bytes arrive in transmission order from logic on i_clk,
// with mode and tag flag valid beside the field end pulse
`timescale 1ns/1ps
`default_nettype none
`include "aff_regs.vh"

module aff_parser
(
    input wire i_clk,
    input wire i_nrst,
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    input wire i_field_end,
    input wire [1:0] i_mode,
    input wire i_tag_flag,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output reg o_data_valid,
    output reg [7:0] o_data,
    output reg [4:0] o_app_type,
    output reg [2:0] o_app_class,
    output reg [1:0] o_sub_index,
    output reg o_sub_first,
    output reg o_sub_last,
    output reg o_busy
);

    // =========================================================
    // states and helpers
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_LIST = 3'h2;
    localparam S_CHECK = 3'h3;
    localparam S_EMIT = 3'h4;
    localparam S_DONE = 3'h5;

    // sub-field byte count from the 3-bit length code
    function [5:0] len_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0: len_decode = 6'h04;
                3'h1: len_decode = 6'h06;
                3'h2: len_decode = 6'h08;
                3'h3: len_decode = 6'h0C;
                3'h4: len_decode = 6'h10;
                3'h5: len_decode = 6'h18;
                3'h6: len_decode = 6'h20;
                default: len_decode = 6'h30;
            endcase
        end
    endfunction

    // application class of a type code
    function [2:0] type_class;
        input [4:0] t;
        begin
            if (t == `AFF_TYPE_LEN_IND)
                type_class = `AFF_CLS_LEN;
            else if (t == `AFF_TYPE_LABEL_S || t == `AFF_TYPE_LABEL_C)
                type_class = `AFF_CLS_LABEL;
            else if (t >= `AFF_TYPE_OBJ_LO && t <= `AFF_TYPE_OBJ_HI)
                type_class = `AFF_CLS_OBJ;
            else if (t == `AFF_TYPE_BAD)
                type_class = `AFF_CLS_BAD;
            else if (t == `AFF_TYPE_END)
                type_class = 3'h0;
            else
                type_class = `AFF_CLS_USER;
        end
    endfunction

    // =========================================================
    // field store and state
    reg [7:0] field_mem [0:255];
    reg [7:0] nbytes;
    reg [2:0] state;
    reg [1:0] mode;
    reg tag_flag;
    reg [1:0] ctrl;
    reg [`AFF_ERR_W-1:0] err;
    reg [`AFF_ERR_W-1:0] err_set;
    reg [15:0] frame_cnt;
    reg [4:0] sub_type [0:3];
    reg [5:0] sub_len [0:3];
    reg [2:0] sub_cnt;
    reg [2:0] tag_idx;
    reg [7:0] pos;
    reg [1:0] si;
    reg [5:0] rem;
    reg [4:0] held_type;
    reg [5:0] held_len;
    reg held_ok;
    reg [8:0] total;
    wire [7:0] lbyte;
    wire [4:0] ltype;
    wire [4:0] cur_type;
    wire drop_now;

    // fields are stored as sent; logical byte k sits at the far end,
    // so reading backwards undoes the byte reversal
    assign lbyte = field_mem[nbytes - 8'h01 - pos];
    assign ltype = lbyte[`AFF_TYPE_MSB:0];
    assign cur_type = sub_type[si];

    // a dropped byte raises no pulse, marks included
    assign drop_now = cur_type == `AFF_TYPE_BAD && ctrl[`AFF_CTRL_DROP_BAD];

    // sum of tagged sub-field lengths for the total check
    integer k;
    // reset loop has its own index: one driver each
    integer j;
    always @*
    begin
        total = 9'h000;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (k < sub_cnt)
                total = total + {3'h0, sub_len[k]};
        end
    end

    // field byte capture while idle; overflow pulses the error set for one cycle and is held in err
    always @(posedge i_clk)
    begin
        if (state == S_IDLE && i_byte_valid && nbytes != 8'hFF)
            field_mem[nbytes] <= i_byte;
    end

    // =========================================================
    // parse sequence
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            state <= S_IDLE;
            nbytes <= 8'h00;
            mode <= `AFF_MODE_NONE;
            tag_flag <= 1'b0;
            sub_cnt <= 3'h0;
            tag_idx <= 3'h0;
            pos <= 8'h00;
            si <= 2'h0;
            rem <= 6'h00;
            held_type <= 5'h00;
            held_len <= 6'h00;
            held_ok <= 1'b0;
            frame_cnt <= 16'h0000;
            err_set <= {`AFF_ERR_W{1'b0}};
            o_data_valid <= 1'b0;
            o_data <= 8'h00;
            o_app_type <= 5'h00;
            o_app_class <= 3'h0;
            o_sub_index <= 2'h0;
            o_sub_first <= 1'b0;
            o_sub_last <= 1'b0;
            o_busy <= 1'b0;
            for (j = 0; j < 4; j = j + 1)
            begin
                sub_type[j] <= 5'h00;
                sub_len[j] <= 6'h00;
            end
        end
        else
        begin
            err_set <= {`AFF_ERR_W{1'b0}};
            o_data_valid <= 1'b0;
            o_sub_first <= 1'b0;
            o_sub_last <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    o_busy <= 1'b0;
                    // count stops at the largest legal field
                    if (i_byte_valid)
                    begin
                        if (nbytes == `AFF_MAX_FIELD)
                            err_set[`AFF_ERR_OVF] <= 1'b1;
                        else
                            nbytes <= nbytes + 8'h01;
                    end
                    if (i_field_end && ctrl[`AFF_CTRL_EN])
                    begin
                        mode <= i_mode;
                        tag_flag <= i_tag_flag;
                        o_busy <= 1'b1;
                        pos <= 8'h00;
                        tag_idx <= 3'h0;
                        sub_cnt <= 3'h0;
                        si <= 2'h0;
                        frame_cnt <= frame_cnt + 16'h0001;
                        state <= S_SETUP;
                    end
                    else if (i_field_end)
                        nbytes <= 8'h00;
                end
                S_SETUP:
                begin
                    state <= S_DONE;
                    if (mode == `AFF_MODE_SHORT)
                    begin
                        if (nbytes != `AFF_SHORT_BYTES)
                            err_set[`AFF_ERR_SHORT_LEN] <= 1'b1;
                        else if (tag_flag && lbyte[7:`AFF_LEN_LSB] != 3'h0)
                            err_set[`AFF_ERR_RSVD] <= 1'b1;
                        // nonzero reserved bits refuse the frame
                        else if (tag_flag)
                        begin
                            // one tag then three data bytes
                            sub_type[0] <= ltype;
                            sub_len[0] <= `AFF_SHORT_DATA;
                            rem <= `AFF_SHORT_DATA;
                            pos <= 8'h01;
                            // type zero: field carries nothing
                            if (ltype != `AFF_TYPE_END)
                            begin
                                sub_cnt <= 3'h1;
                                state <= S_EMIT;
                            end
                        end
                        else if (!held_ok)
                            err_set[`AFF_ERR_NO_CTX] <= 1'b1;
                        else
                        begin
                            // untagged four bytes continue the held type
                            sub_type[0] <= held_type;
                            sub_len[0] <= 6'h04;
                            rem <= 6'h04;
                            sub_cnt <= 3'h1;
                            state <= S_EMIT;
                        end
                    end
                    else if (mode == `AFF_MODE_VAR)
                    begin
                        if (tag_flag)
                            state <= S_LIST;
                        else if (!held_ok || {2'h0, held_len} != nbytes)
                            err_set[`AFF_ERR_NO_CTX] <= 1'b1;
                        else
                        begin
                            sub_type[0] <= held_type;
                            sub_len[0] <= held_len;
                            rem <= held_len;
                            sub_cnt <= 3'h1;
                            state <= S_EMIT;
                        end
                    end
                    else if (mode != `AFF_MODE_NONE)
                        err_set[`AFF_ERR_MODE] <= 1'b1;
                end
                S_LIST:
                begin
                    // walk the tag list from the logical start
                    if (tag_idx == `AFF_MAX_TAGS || ltype == `AFF_TYPE_END)
                    begin
                        sub_cnt <= tag_idx;
                        pos <= (tag_idx == `AFF_MAX_TAGS) ? 8'h04 : {5'h00, tag_idx} + 8'h01;
                        state <= S_CHECK;
                    end
                    else
                    begin
                        sub_type[tag_idx[1:0]] <= ltype;
                        sub_len[tag_idx[1:0]] <= len_decode(lbyte[7:`AFF_LEN_LSB]);
                        tag_idx <= tag_idx + 3'h1;
                        pos <= pos + 8'h01;
                    end
                end
                S_CHECK:
                begin
                    // list bytes plus sub-fields must make the whole field
                    if (total + {1'b0, pos} != {1'b0, nbytes})
                    begin
                        err_set[`AFF_ERR_TOTAL] <= 1'b1;
                        state <= S_DONE;
                    end
                    else if (sub_cnt == 3'h0)
                        state <= S_DONE;
                    else
                    begin
                        rem <= sub_len[0];
                        state <= S_EMIT;
                    end
                end
                S_EMIT:
                begin
                    // zero padding passes through as data; its length is
                    // known only inside the data group itself
                    if (cur_type == `AFF_TYPE_BAD)
                        err_set[`AFF_ERR_TYPE31] <= 1'b1;
                    o_data_valid <= !drop_now;
                    o_data <= lbyte;
                    o_app_type <= cur_type;
                    o_app_class <= type_class(cur_type);
                    o_sub_index <= si;
                    o_sub_first <= (rem == sub_len[si]) && !drop_now;
                    o_sub_last <= (rem == 6'h01) && !drop_now;
                    pos <= pos + 8'h01;
                    if (rem != 6'h01)
                        rem <= rem - 6'h01;
                    else if ({1'b0, si} + 3'h1 == sub_cnt)
                    begin
                        // the last sub-field carries over to the next frame
                        held_type <= cur_type;
                        held_len <= (mode == `AFF_MODE_VAR) ? sub_len[si] : 6'h04;
                        held_ok <= 1'b1;
                        state <= S_DONE;
                    end
                    else
                    begin
                        si <= si + 2'h1;
                        rem <= sub_len[si + 2'h1];
                    end
                end
                S_DONE:
                begin
                    // a field with no extended data breaks any continuation
                    if (mode == `AFF_MODE_NONE || sub_cnt == 3'h0)
                        held_ok <= 1'b0;
                    nbytes <= 8'h00;
                    o_busy <= 1'b0;
                    state <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    // =========================================================
    // register port: read data one cycle after the strobe
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ctrl <= `AFF_CTRL_RESET;
            err <= {`AFF_ERR_W{1'b0}};
            o_rdata <= 32'h00000000;
        end
        else
        begin
            // only the two low bits are kept
            if (i_wr && i_addr == `AFF_REG_CTRL)
                ctrl <= i_wdata[1:0];
            // write one to clear; a new event in the same cycle wins
            if (i_wr && i_addr == `AFF_REG_ERR)
                err <= (err & ~i_wdata[`AFF_ERR_W-1:0]) | err_set;
            else
                err <= err | err_set;
            o_rdata <= 32'h00000000;
            if (i_rd)
            begin
                // unmapped addresses read as zero
                case (i_addr)
                    `AFF_REG_CTRL: o_rdata <= {30'h0, ctrl};
                    `AFF_REG_STATUS:
                        o_rdata <= {11'h000, held_len, held_type, held_ok, sub_cnt, tag_flag, mode, state};
                    `AFF_REG_ERR: o_rdata <= {25'h0, err};
                    `AFF_REG_COUNT: o_rdata <= {16'h0, frame_cnt};
                    default: o_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: tb/aff_monitor.sv
// checker for the auxiliary field parser, bound to its ports
// assumes one clock, synchronous active-low reset, ctrl written at 0x00
`timescale 1ns/1ps
`default_nettype none
`include "aff_regs.vh"
module aff_monitor
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    input wire logic i_field_end,
    input wire logic [1:0] i_mode,
    input wire logic i_tag_flag,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_data_valid,
    input wire logic [4:0] o_app_type,
    input wire logic [2:0] o_app_class,
    input wire logic [1:0] o_sub_index,
    input wire logic o_sub_first,
    input wire logic o_sub_last,
    input wire logic o_busy
);
    // ==========================================
    // frame context rebuilt from the pins only
    logic en;
    logic [1:0] lmode;
    logic lflag;
    logic [7:0] last_byte;
    logic [7:0] ltag;
    logic [7:0] vcnt;
    // last received byte is logical byte 0, the tag when one is present
    always @(posedge i_clk)
    begin
        if (!i_nrst)
            {en, lmode, lflag, last_byte, ltag, vcnt} <= '0;
        else
        begin
            if (i_wr && i_addr == `AFF_REG_CTRL)
                en <= i_wdata[0];
            if (i_byte_valid && !o_busy)
                last_byte <= i_byte;
            if (i_field_end)
                {lmode, lflag, ltag} <= {i_mode, i_tag_flag, last_byte};
            if (i_field_end)
                vcnt <= 8'h00;
            else if (o_data_valid)
                vcnt <= vcnt + 8'h01;
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_start;
        i_field_end && en && !o_busy;
    endsequence
    sequence s_short_last;
        o_data_valid && o_sub_last && lmode == `AFF_MODE_SHORT;
    endsequence
    a_busy_starts: assert property (s_start |=> o_busy)
        else $error("busy missing after field end");
    a_busy_bounded: assert property ($rose(o_busy) |-> ##[1:260] !o_busy)
        else $error("parse ran too long");
    a_valid_in_busy: assert property (o_data_valid |-> o_busy)
        else $error("data outside parse");
    a_mark_with_valid: assert property ((o_sub_first || o_sub_last) |-> o_data_valid)
        else $error("sub-field mark without data");
    a_short_count: assert property (s_short_last |-> vcnt == (lflag ? 8'h02 : 8'h03))
        else $error("short sub-field length wrong");
    a_short_tag: assert property (o_data_valid && lmode == `AFF_MODE_SHORT && lflag
        |-> o_app_type == ltag[4:0] && ltag[7:5] == 3'h0)
        else $error("short type not from tag");
    a_first_index: assert property (o_data_valid && vcnt == 8'h00 |-> o_sub_first && o_sub_index == 2'h0)
        else $error("first byte not first sub-field");
    a_end_silent: assert property (o_data_valid |-> o_app_type != 5'h00)
        else $error("end marker type emitted data");
    a_class_invalid: assert property (o_data_valid && o_app_type == 5'h1F |-> o_app_class == 3'h5)
        else $error("type 31 not invalid");
    a_class_object: assert property (o_data_valid && o_app_type inside {[12:15]} |-> o_app_class == 3'h3)
        else $error("object type class wrong");
    a_class_fixed: assert property (o_data_valid && o_app_type inside {[1:3]}
        |-> o_app_class == (o_app_type == 5'h01 ? 3'h1 : 3'h2))
        else $error("length or label class wrong");
    a_class_user: assert property (o_data_valid && o_app_type inside {[4:11], [16:30]} |-> o_app_class == 3'h4)
        else $error("user type class wrong");
endmodule
`default_nettype wire

// File: tb/aff_sender.sv
// far-side model: the frame multiplexer handing one field per frame
// assumes the parser samples on rising edges; bytes leave in reversed order
`timescale 1ns/1ps
`default_nettype none
module aff_sender
(
    input wire logic i_clk,
    output var logic o_valid,
    output var logic [7:0] o_byte,
    output var logic o_end,
    output var logic [1:0] o_mode,
    output var logic o_flag
);
    initial {o_valid, o_byte, o_end, o_mode, o_flag} = '0;
    // ==========================================
    // one field; a gap makes the model slow, released lines show inverse
    task automatic send(input logic [7:0] f[$], input logic [1:0] m, input logic fl, input int gap);
        for (int i = f.size() - 1; i >= 0; i--)
        begin
            @(posedge i_clk);
            o_valid <= 1'b1;
            o_byte <= f[i];
            if (gap != 0)
            begin
                @(posedge i_clk);
                o_valid <= 1'b0;
                o_byte <= ~f[i];
            end
        end
        // mode and flag only mean something beside the end pulse
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_byte <= ~o_byte;
        o_end <= 1'b1;
        o_mode <= m;
        o_flag <= fl;
        @(posedge i_clk);
        o_end <= 1'b0;
        o_mode <= ~m;
        o_flag <= ~fl;
    endtask
endmodule
`default_nettype wire

// File: tb/test_aux_data_field_framer.sv
// self-checking bench for the auxiliary field parser
// assumes aff_parser, aff_sender and aff_monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "aff_regs.vh"
module test_aux_data_field_framer;
    // ==========================================
    // clock, wiring, scoreboard
    logic i_clk, i_nrst, i_wr, i_rd, loose, i_byte_valid, i_field_end, i_tag_flag;
    logic o_data_valid, o_sub_first, o_sub_last, o_busy;
    logic [1:0] i_mode, o_sub_index;
    logic [7:0] i_byte, i_addr, o_data;
    logic [4:0] o_app_type;
    logic [2:0] o_app_class;
    logic [31:0] i_wdata, o_rdata;
    logic [7:0] fld[$];
    logic [31:0] expq[$];
    int bad_count = 0;
    int comparisons = 0;
    int lens[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    aff_parser i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
        .i_field_end(i_field_end), .i_mode(i_mode), .i_tag_flag(i_tag_flag), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_data_valid(o_data_valid),
        .o_data(o_data), .o_app_type(o_app_type), .o_app_class(o_app_class), .o_sub_index(o_sub_index),
        .o_sub_first(o_sub_first), .o_sub_last(o_sub_last), .o_busy(o_busy));
    aff_sender i_src (.i_clk(i_clk), .o_valid(i_byte_valid), .o_byte(i_byte), .o_end(i_field_end),
        .o_mode(i_mode), .o_flag(i_tag_flag));
    // ==========================================
    // helpers
    task automatic close_out();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [2:0] cls(input logic [4:0] t);
        if (t == `AFF_TYPE_BAD) return `AFF_CLS_BAD;
        if (t >= `AFF_TYPE_OBJ_LO && t <= `AFF_TYPE_OBJ_HI) return `AFF_CLS_OBJ;
        if (t == `AFF_TYPE_LEN_IND) return `AFF_CLS_LEN;
        if (t == `AFF_TYPE_LABEL_S || t == `AFF_TYPE_LABEL_C) return `AFF_CLS_LABEL;
        return `AFF_CLS_USER;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & mk, e);
    endtask
    // data bytes of one sub-field, last z of them zero padding; type 0 expects nothing
    task automatic sub(input logic [4:0] t, input logic [1:0] x, input int n, input int z);
        logic [7:0] b;
        for (int k = 0; k < n; k++)
        begin
            b = (k >= n - z) ? 8'h00 : 8'($urandom());
            fld.push_back(b);
            if (t != 5'h00)
                expq.push_back({12'h000, b, t, cls(t), x, k == 0, k == n - 1});
        end
    endtask
    task automatic go(input logic [1:0] m, input logic fl, input int gap);
        int n;
        n = 0;
        i_src.send(fld, m, fl, gap);
        fld.delete();
        @(posedge i_clk);
        #1;
        while (o_busy !== 1'b0 && n < 400)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 400)
        begin
            bad_count++;
            close_out();
        end
    endtask
    // ==========================================
    // output watcher: each emitted byte while loose is clear against the oldest note
    always @(posedge i_clk)
    begin
        #1;
        if (o_data_valid === 1'b1 && !loose)
        begin
            if (expq.size() == 0)
                chk({12'h000, o_data, o_app_type, o_app_class, o_sub_index, o_sub_first, o_sub_last}, 32'hFFFFFFFF);
            else
                chk({12'h000, o_data, o_app_type, o_app_class, o_sub_index, o_sub_first, o_sub_last},
                    expq.pop_front());
        end
    end
    // ==========================================
    // main sequence
    initial
    begin
        {i_nrst, i_wr, i_rd, i_addr, i_wdata, loose} = '0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        void'($urandom(7));
        rd_chk(`AFF_REG_CTRL, 32'h0, 32'hFFFFFFFF);
        rd_chk(`AFF_REG_ERR, 32'h0, 32'hFFFFFFFF);
        rd_chk(`AFF_REG_COUNT, 32'h0, 32'hFFFFFFFF);
        rd_chk(8'h10 + 8'($urandom_range(239)), 32'h0, 32'hFFFFFFFF);
        wr(`AFF_REG_CTRL, ($urandom() & ~32'h2) | 32'h1);
        rd_chk(`AFF_REG_CTRL, 32'h1, 32'hFFFFFFFF);
        // short: tagged start, slow untagged continuation, padded length field
        fld.push_back(8'h02);
        sub(5'h02, 2'h0, 3, 0);
        go(`AFF_MODE_SHORT, 1'b1, 0);
        sub(5'h02, 2'h0, 4, 0);
        go(`AFF_MODE_SHORT, 1'b0, 1);
        fld.push_back(8'h01);
        sub(5'h01, 2'h0, 3, 2);
        go(`AFF_MODE_SHORT, 1'b1, 0);
        fld.push_back(8'h00);
        sub(5'h00, 2'h0, 3, 0);
        go(`AFF_MODE_SHORT, 1'b1, 0);
        // refused short fields: reserved bits, lost context, wrong length
        fld.push_back(8'hE4);
        sub(5'h00, 2'h0, 3, 0);
        go(`AFF_MODE_SHORT, 1'b1, 0);
        rd_chk(`AFF_REG_ERR, 32'h2, 32'h2);
        go(`AFF_MODE_NONE, 1'b0, 0);
        sub(5'h00, 2'h0, 4, 0);
        go(`AFF_MODE_SHORT, 1'b0, 0);
        rd_chk(`AFF_REG_ERR, 32'h4, 32'h4);
        fld.push_back(8'h04);
        sub(5'h00, 2'h0, 4, 0);
        go(`AFF_MODE_SHORT, 1'b1, 0);
        rd_chk(`AFF_REG_ERR, 32'h1, 32'h1);
        wr(`AFF_REG_ERR, $urandom() | 32'h7F);
        rd_chk(`AFF_REG_ERR, 32'h0, 32'hFFFFFFFF);
        // variable: every length code, one sub-field closed by end marker
        for (int c = 0; c < 8; c++)
        begin
            fld.push_back({3'(c), 5'(4 + c)});
            fld.push_back(8'h00);
            sub(5'(4 + c), 2'h0, lens[c], 0);
            go(`AFF_MODE_VAR, 1'b1, c % 2);
        end
        sub(5'h0B, 2'h0, 48, 0);
        go(`AFF_MODE_VAR, 1'b0, 0);
        sub(5'h00, 2'h0, 8, 0);
        go(`AFF_MODE_VAR, 1'b0, 0);
        rd_chk(`AFF_REG_ERR, 32'h4, 32'h4);
        // full list of four tags, no end marker, object types in order
        for (int s = 0; s < 4; s++)
            fld.push_back({3'(s), 5'(12 + s)});
        for (int s = 0; s < 4; s++)
            sub(5'(12 + s), 2'(s), lens[s], 0);
        go(`AFF_MODE_VAR, 1'b1, 0);
        // type 31: first pass unscored, second dropped; then reserved mode
        loose = 1'b1;
        for (int d = 0; d < 2; d++)
        begin
            fld.push_back(8'h1F);
            fld.push_back(8'h00);
            sub(5'h00, 2'h0, 4, 0);
            go(`AFF_MODE_VAR, 1'b1, 0);
            loose = 1'b0;
            wr(`AFF_REG_CTRL, $urandom() | 32'h3);
        end
        fld.push_back(8'h04);
        sub(5'h00, 2'h0, 3, 0);
        go(2'h3, 1'b1, 0);
        rd_chk(`AFF_REG_ERR, 32'h30, 32'h30);
        chk(32'(expq.size()), 32'h0);
        close_out();
    end
endmodule
bind aff_parser aff_monitor i_mon
(
    .i_clk(i_clk), .i_nrst(i_nrst), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .i_field_end(i_field_end), .i_mode(i_mode), .i_tag_flag(i_tag_flag), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .o_data_valid(o_data_valid), .o_app_type(o_app_type),
    .o_app_class(o_app_class), .o_sub_index(o_sub_index), .o_sub_first(o_sub_first),
    .o_sub_last(o_sub_last), .o_busy(o_busy)
);
`default_nettype wire
